//--- rtl/hka_sequencer.sv
// Housekeeping converter sequencer with AXI4-Lite register slave
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module hka_sequencer (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        osc_tick,
	input  wire logic        sleep_tick,
	input  wire logic        alt_tick,
	input  wire logic [7:0]  comparator_code,
	output logic [2:0]       channel_select,
	output logic [2:0]       reference_select,
	output logic             sample_switch,
	output logic             converter_enable,
	output logic             irq
);
	// Ticks are one-cycle enables from the clock regime; comparator_code
	// is the analog core's digitised sample of the held voltage.
	logic [2:0]  chan_reg;
	logic [2:0]  vref_reg;
	logic [1:0]  div_reg;
	logic        en_reg;
	logic [2:0]  src_reg;
	logic [7:0]  result_reg;
	logic        ready_reg;
	logic [1:0]  irq_stat_reg;
	logic [1:0]  irq_mask_reg;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic [1:0]  osc_div_reg;
	logic [3:0]  div_cnt_reg;
	logic [3:0]  phase_cnt_reg;
	logic        settle_reg;
	logic        trig_pend_reg;
	logic [7:0]  shadow_reg;
	hka_pkg::hka_state_type state_reg;
	hka_pkg::hka_state_type state_next;

	function automatic logic [3:0] ratio_top(input logic [1:0] code);
		// Terminal count of the ratio divider
		case (code)
			2'b11:   ratio_top = 4'hF;
			2'b10:   ratio_top = 4'h7;
			2'b01:   ratio_top = 4'h3;
			default: ratio_top = 4'h1;
		endcase
	endfunction

	// Write path: address and data are taken independently
	wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire wr_ctl   = do_write && awaddr_reg == hka_pkg::ADDR_CONTROL_TWO;
	wire wr_cfg   = do_write && awaddr_reg == hka_pkg::ADDR_CONFIG;
	wire wr_src   = do_write && awaddr_reg == hka_pkg::ADDR_CLKSRC;
	wire wr_trig  = do_write && awaddr_reg == hka_pkg::ADDR_TRIGGER;
	wire wr_istat = do_write && awaddr_reg == hka_pkg::ADDR_IRQ_STATUS;
	wire wr_imask = do_write && awaddr_reg == hka_pkg::ADDR_IRQ_MASK;
	wire wr_known = wr_ctl || wr_cfg || wr_src || wr_trig ||
		wr_istat || wr_imask ||
		(do_write && awaddr_reg == hka_pkg::ADDR_RESULT) ||
		(do_write && awaddr_reg == hka_pkg::ADDR_STATUS);
	wire b0 = wstrb_reg[0];
	wire b1 = wstrb_reg[1];

	// Source selection and ratio divider
	wire src_tick =
		(src_reg == hka_pkg::SRC_OSC_DIV4) ? (osc_tick && osc_div_reg == 2'h3) :
		(src_reg == hka_pkg::SRC_OSC)      ? osc_tick :
		(src_reg == hka_pkg::SRC_SLEEP)    ? sleep_tick : alt_tick;
	// Compare with >= so a ratio cut mid-count ends the period at once
	// instead of wrapping the counter through sixteen extra ticks
	wire conv_tick = src_tick && div_cnt_reg >= ratio_top(div_reg);

	wire phase_last = (state_reg == hka_pkg::ST_ACQ &&
			phase_cnt_reg == hka_pkg::ACQ_CYCLES - 4'h1) ||
		(state_reg == hka_pkg::ST_RESOLVE &&
			phase_cnt_reg == hka_pkg::RESOLVE_CYCLES - 4'h1) ||
		(state_reg == hka_pkg::ST_LATENCY &&
			phase_cnt_reg == hka_pkg::LATENCY_CYCLES - 4'h1);
	wire done_evt = conv_tick && phase_last &&
		state_reg == hka_pkg::ST_LATENCY;
	// A trigger is held until the channel has had a full cycle to settle
	wire start = conv_tick && trig_pend_reg && !settle_reg &&
		state_reg == hka_pkg::ST_IDLE;
	// Result saturates at full scale from the core's own clamp
	wire [7:0] sat_code = comparator_code;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			hka_pkg::ST_IDLE:
				if (start) state_next = hka_pkg::ST_ACQ;
			hka_pkg::ST_ACQ:
				if (conv_tick && phase_last)
					state_next = hka_pkg::ST_RESOLVE;
			hka_pkg::ST_RESOLVE:
				if (conv_tick && phase_last)
					state_next = hka_pkg::ST_LATENCY;
			hka_pkg::ST_LATENCY:
				if (conv_tick && phase_last)
					state_next = hka_pkg::ST_IDLE;
			default: state_next = hka_pkg::ST_IDLE;
		endcase
	end

	wire [31:0] rd_word =
		(s_axi_araddr == hka_pkg::ADDR_CONTROL_TWO) ?
			{24'h00_0000, chan_reg, 5'h00} :
		(s_axi_araddr == hka_pkg::ADDR_CONFIG) ?
			{26'h000_0000, en_reg, div_reg, vref_reg} :
		(s_axi_araddr == hka_pkg::ADDR_CLKSRC) ?
			{21'h00_0000, src_reg, 8'h00} :
		(s_axi_araddr == hka_pkg::ADDR_RESULT) ?
			{24'h00_0000, result_reg} :
		(s_axi_araddr == hka_pkg::ADDR_STATUS) ?
			{30'h0000_0000, state_reg != hka_pkg::ST_IDLE || trig_pend_reg,
				ready_reg} :
		(s_axi_araddr == hka_pkg::ADDR_IRQ_STATUS) ?
			{30'h0000_0000, irq_stat_reg} :
		(s_axi_araddr == hka_pkg::ADDR_IRQ_MASK) ?
			{30'h0000_0000, irq_mask_reg} : 32'h0000_0000;
	wire rd_known = s_axi_araddr == hka_pkg::ADDR_CONTROL_TWO ||
		s_axi_araddr == hka_pkg::ADDR_CONFIG ||
		s_axi_araddr == hka_pkg::ADDR_CLKSRC ||
		s_axi_araddr == hka_pkg::ADDR_RESULT ||
		s_axi_araddr == hka_pkg::ADDR_STATUS ||
		s_axi_araddr == hka_pkg::ADDR_IRQ_STATUS ||
		s_axi_araddr == hka_pkg::ADDR_IRQ_MASK;
	wire rd_take = s_axi_arvalid && s_axi_arready;

	// Bus handshakes; AW, W and B each have their own register process, AR and R share one
	wire b_done = s_axi_bvalid && s_axi_bready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			awaddr_reg    <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg   <= 1'b1;
				awaddr_reg    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (b_done)
				aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg   <= 1'b0;
			wdata_reg    <= 32'h0000_0000;
			wstrb_reg    <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_reg && !s_axi_wready;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (b_done)
				w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
			end
			if (b_done)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (rd_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_known ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_reg     <= hka_pkg::CHAN_RESET;
			vref_reg     <= hka_pkg::VREF_RESET;
			div_reg      <= hka_pkg::DIV_RESET;
			en_reg       <= 1'b0;
			src_reg      <= hka_pkg::SRC_RESET;
			irq_mask_reg <= 2'b00;
		end else begin
			if (wr_ctl && b0)
				chan_reg <= wdata_reg[hka_pkg::CHAN_LSB +: 3];
			if (wr_cfg && b0) begin
				vref_reg <= wdata_reg[hka_pkg::VREF_LSB +: 3];
				div_reg  <= wdata_reg[hka_pkg::DIV_LSB +: 2];
				en_reg   <= wdata_reg[hka_pkg::EN_BIT];
			end
			if (wr_src && b1)
				src_reg <= wdata_reg[hka_pkg::SRC_LSB +: 3];
			if (wr_imask && b0)
				irq_mask_reg <= wdata_reg[1:0];
		end
	end

	// Clock dividers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_div_reg <= 2'h0;
			div_cnt_reg <= 4'h0;
		end else begin
			if (osc_tick)
				osc_div_reg <= osc_div_reg + 2'h1;
			if (conv_tick)
				div_cnt_reg <= 4'h0;
			else if (src_tick)
				div_cnt_reg <= div_cnt_reg + 4'h1;
		end
	end

	// Conversion sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg     <= hka_pkg::ST_IDLE;
			phase_cnt_reg <= 4'h0;
			settle_reg    <= 1'b0;
			trig_pend_reg <= 1'b0;
			shadow_reg    <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (wr_ctl && b0)
				settle_reg <= 1'b1;
			else if (conv_tick)
				settle_reg <= 1'b0;
			// Retriggers during a conversion are kept for the next one
			if (wr_trig)
				trig_pend_reg <= 1'b1;
			else if (start)
				trig_pend_reg <= 1'b0;
			if (conv_tick && state_reg != hka_pkg::ST_IDLE)
				phase_cnt_reg <= phase_last ? 4'h0 :
					phase_cnt_reg + 4'h1;
			if (conv_tick && state_reg == hka_pkg::ST_ACQ && phase_last)
				shadow_reg <= sat_code;
		end
	end

	// Result, ready flag and interrupts; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_reg   <= 8'h00;
			ready_reg    <= 1'b0;
			irq_stat_reg <= 2'b00;
			irq          <= 1'b0;
		end else begin
			if (done_evt) begin
				result_reg <= shadow_reg;
				ready_reg  <= 1'b1;
			end else if (wr_trig) begin
				ready_reg <= 1'b0;
			end
			irq_stat_reg[0] <= done_evt ||
				(irq_stat_reg[0] && !(wr_istat && b0 && wdata_reg[0]));
			irq_stat_reg[1] <= (wr_trig && state_reg != hka_pkg::ST_IDLE) ||
				(irq_stat_reg[1] && !(wr_istat && b0 && wdata_reg[1]));
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Pin-facing outputs
	// The switch follows the next state so it closes on the start tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_select   <= hka_pkg::CHAN_RESET;
			reference_select <= hka_pkg::VREF_RESET;
			sample_switch    <= 1'b0;
			converter_enable <= 1'b0;
		end else begin
			channel_select   <= chan_reg;
			reference_select <= vref_reg;
			sample_switch    <= state_next == hka_pkg::ST_ACQ;
			converter_enable <= en_reg;
		end
	end
endmodule // hka_sequencer

//--- rtl/hka_pkg.sv
// Constants for the housekeeping converter sequencer
package hka_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CONTROL_TWO = 8'h00;
	localparam logic [7:0] ADDR_CONFIG      = 8'h04;
	localparam logic [7:0] ADDR_CLKSRC      = 8'h08;
	localparam logic [7:0] ADDR_TRIGGER     = 8'h0C;
	localparam logic [7:0] ADDR_RESULT      = 8'h10;
	localparam logic [7:0] ADDR_STATUS      = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1C;
	// Field positions
	localparam int CHAN_LSB  = 5;
	localparam int VREF_LSB  = 0;
	localparam int DIV_LSB   = 3;
	localparam int EN_BIT    = 5;
	localparam int SRC_LSB   = 8;
	// Reset values
	localparam logic [2:0] CHAN_RESET = 3'h0;
	localparam logic [2:0] VREF_RESET = 3'h0;
	localparam logic [1:0] DIV_RESET  = 2'h3;
	localparam logic [2:0] SRC_RESET  = 3'h0;
	// Clock source codes
	localparam logic [2:0] SRC_OSC_DIV4 = 3'h0;
	localparam logic [2:0] SRC_OSC      = 3'h1;
	localparam logic [2:0] SRC_SLEEP    = 3'h2;
	// Conversion phase lengths, in conversion clock cycles
	localparam logic [3:0] ACQ_CYCLES     = 4'h3;
	localparam logic [3:0] RESOLVE_CYCLES = 4'h8;
	localparam logic [3:0] LATENCY_CYCLES = 4'h4;
	localparam logic [3:0] SETTLE_CYCLES  = 4'h1;
	// Reference select codes
	localparam logic [2:0] VREF_EXT = 3'h3;
	// Sequencer states, Gray coded along the conversion path
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ACQ     = 3'b001,
		ST_RESOLVE = 3'b011,
		ST_LATENCY = 3'b010
	} hka_state_type;
endpackage

//--- verif/hka_monitor.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/100ps
module hka_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        sample_switch,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("write answer dropped");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read not held");
	reset_quiet_a: assert property (disable iff (1'b0) !aresetn
		|=> !s_axi_bvalid && !s_axi_rvalid && !sample_switch && !irq)
		else $error("outputs active in reset");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > 8'h1C |=> s_axi_rresp == 2'b10
		&& s_axi_rdata == 32'h0000_0000) else $error("unmapped read answered");
	acq_min_a: assert property ($rose(sample_switch)
		|-> sample_switch[*3]) else $error("acquisition too short");
	acq_bound_a: assert property ($rose(sample_switch)
		|-> ##[3:1000] !sample_switch) else $error("switch never opened");
	// Resolve and transfer take 12 ticks, so the switch cannot reclose soon
	hold_gap_a: assert property ($fell(sample_switch)
		|-> !sample_switch[*8]) else $error("switch reclosed early");
	cover property ($rose(sample_switch));
	cover property ($rose(irq));
	cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // hka_monitor
bind hka_sequencer hka_monitor i_hka_monitor (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .sample_switch, .irq);

//--- verif/hka_analog_model.sv
// Analog sources on the converter inputs, seen through the comparator
`timescale 1ns/100ps
module hka_analog_model #(
	parameter int SUPPLY_MV = 2600
) (
	input wire logic        aclk,
	input wire logic [11:0] level_mv [8],
	input wire logic [2:0]  channel_select,
	input wire logic [2:0]  reference_select,
	output logic [7:0]      comparator_code
);
	int vin;
	int vref;
	always @(posedge aclk) begin
		vin = (channel_select == 3'h7) ? 1826 : level_mv[channel_select];
		case (reference_select)
			3'h0: vref = 1826;
			3'h1: vref = 1217;
			3'h2: vref = 609;
			3'h3: vref = level_mv[6];
			default: vref = SUPPLY_MV;
		endcase
		comparator_code <= (vin >= vref) ? 8'hFF : 8'(vin * 255 / vref);
	end
endmodule // hka_analog_model

//--- verif/testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
module testbench;
	logic        aclk, aresetn, osc_tick, sleep_tick, alt_tick;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, comparator_code;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat, old;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rresp, wresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, sample_switch, converter_enable;
	logic        irq;
	logic [2:0]  channel_select, reference_select;
	logic [11:0] level_mv [8];
	int          failures, num_checks, seed, i, vr, src, dv;

	hka_sequencer i_hka_sequencer (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_tick,
		.sleep_tick, .alt_tick, .comparator_code, .channel_select,
		.reference_select, .sample_switch, .converter_enable, .irq);
	hka_analog_model i_hka_analog_model (.aclk, .level_mv, .channel_select,
		.reference_select, .comparator_code);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		osc_tick   <= 1'($random(seed));
		sleep_tick <= 1'($random(seed));
		alt_tick   <= 1'($random(seed));
	end

	task results;
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task timeout;
		failures++;
		$display("CHECK FAILED at %0t: no answer", $time);
		results;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				wresp = s_axi_bresp;
				return;
			end
		end
		timeout;
	endtask
	task rd(input logic [7:0] a);
		int k;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				rdat = s_axi_rdata;
				rresp = s_axi_rresp;
				return;
			end
		end
		timeout;
	endtask
	// Poll for ready; the slowest setting needs about 2048 clocks
	task poll;
		int k;
		for (k = 0; k < 2000; k++) begin
			rd(hka_pkg::ADDR_STATUS);
			if (rdat[0] === 1'b1)
				return;
		end
		timeout;
	endtask
	function automatic logic [7:0] expect_code(input int ch, input int r);
		int vin;
		int vref;
		vin = (ch == 7) ? 1826 : level_mv[ch];
		vref = (r == 0) ? 1826 : (r == 1) ? 1217 : (r == 2) ? 609 :
			(r == 3) ? level_mv[6] : 2600;
		return (vin >= vref) ? 8'hFF : 8'(vin * 255 / vref);
	endfunction

	initial begin
		seed = 32'hd65e;
		failures = 0;
		num_checks = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr} = 16'h0000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		for (i = 0; i < 8; i++)
			level_mv[i] = 12'(($random(seed) & 32'h0000_07FF) + 200);
		level_mv[0] = 12'h000;
		level_mv[6] = 12'h7D0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(hka_pkg::ADDR_CONFIG);
		chk(rdat, 32'h0000_0018);
		rd(hka_pkg::ADDR_CLKSRC);
		chk(rdat, 32'h0000_0000);
		wr(hka_pkg::ADDR_CONFIG, 32'h0000_0038);
		chk(wresp, 2'b00);
		@(posedge aclk);
		chk(converter_enable, 1'b1);
		repeat (50) @(posedge aclk);
		wr(hka_pkg::ADDR_TRIGGER, 32'h0000_0001);
		poll;
		for (i = 0; i < 8; i++) begin
			vr = (i + 1) % 8;
			src = (vr < 3) ? 0 : i % 4;
			dv = (vr < 3 || src == 1) ? 3 :
				(src == 0) ? 2 : (i + 2) % 4;
			wr(hka_pkg::ADDR_CLKSRC, 32'(src << 8));
			wr(hka_pkg::ADDR_CONFIG, 32'(32 | (dv << 3) | vr));
			wr(hka_pkg::ADDR_CONTROL_TWO, 32'(i << 5));
			wr(hka_pkg::ADDR_TRIGGER, 32'(i));
			poll;
			chk(channel_select, 32'(i));
			chk(reference_select, 32'(vr));
			rd(hka_pkg::ADDR_RESULT);
			chk(rdat, 32'(expect_code(i, vr)));
		end
		old = rdat;
		wr(hka_pkg::ADDR_TRIGGER, 32'h0000_0001);
		rd(hka_pkg::ADDR_STATUS);
		chk(rdat[0], 1'b0);
		rd(hka_pkg::ADDR_RESULT);
		chk(rdat, old);
		poll;
		chk(irq, 1'b0);
		wr(hka_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b1);
		wr(hka_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		rd(8'h20);
		chk(rdat, 32'h0000_0000);
		chk(rresp, 2'b10);
		wr(8'h24, 32'h0000_0001);
		chk(wresp, 2'b10);
		s_axi_wstrb <= 4'h1;
		wr(hka_pkg::ADDR_CLKSRC, 32'h0000_0300);
		s_axi_wstrb <= 4'hF;
		rd(hka_pkg::ADDR_CLKSRC);
		chk(rdat, 32'h0000_0000);
		wr(hka_pkg::ADDR_RESULT, 32'h0000_00AA);
		rd(hka_pkg::ADDR_RESULT);
		chk(rdat, old);
		results;
	end
endmodule // testbench
